/* File: rtl/hvc_pkg.sv */
/*
 * Shared constants and types of the vendor command handler: opcodes,
 * status codes, parameter limits, register offsets, reset values and
 * the engine states.
 * Assumes a single clock domain and an APB master with 12-bit addresses.
 */
package hvc_pkg;

    // Command opcodes
    localparam logic [15:0] OP_TX_TEST_END = 16'hfc12;
    localparam logic [15:0] OP_ADDR_READ = 16'hfc20;
    localparam logic [15:0] OP_CONT_READ = 16'hfc21;
    localparam logic [15:0] OP_ADDR_WRITE = 16'hfc22;
    localparam logic [15:0] OP_CONT_WRITE = 16'hfc23;
    localparam logic [15:0] OP_POWER_MODE = 16'hfc24;
    localparam logic [15:0] OP_RADIO_ACT = 16'hfc25;
    localparam logic [15:0] OP_TX_POWER = 16'hfc26;

    // Status codes
    localparam logic [7:0] ST_SUCCESS = 8'h00;
    localparam logic [7:0] ST_UNKNOWN_CMD = 8'h01;
    localparam logic [7:0] ST_DISALLOWED = 8'h0c;
    localparam logic [7:0] ST_INVALID_PARAM = 8'h12;

    // Parameter limits and codes
    localparam logic [7:0] MAX_XFER = 8'h40;
    localparam logic [7:0] TEST_MODE_COUNT = 8'h00;
    localparam logic [7:0] TEST_MODE_CM = 8'h01;
    localparam logic [7:0] PM_ACTIVE = 8'h00;
    localparam logic [7:0] PM_LAST = 8'h03;
    localparam logic [7:0] ACT_OFF = 8'h00;
    localparam logic [7:0] ACT_LOW = 8'h01;
    localparam logic [7:0] ACT_HIGH = 8'h02;
    localparam logic [7:0] TXP_LAST = 8'h11;

    // Register byte offsets
    localparam logic [11:0] OFF_OPCODE = 12'h000;
    localparam logic [11:0] OFF_ADDR = 12'h004;
    localparam logic [11:0] OFF_PARAM = 12'h008;
    localparam logic [11:0] OFF_PLEN = 12'h00c;
    localparam logic [11:0] OFF_GO = 12'h010;
    localparam logic [11:0] OFF_STATUS = 12'h014;
    localparam logic [11:0] OFF_RESULT = 12'h018;
    localparam logic [11:0] OFF_STATE = 12'h01c;
    localparam logic [11:0] OFF_DATA = 12'h100;

    // Reset values
    localparam logic [4:0] RST_TX_LEVEL = 5'h00;
    localparam logic [1:0] RST_PMODE = 2'h0;

    typedef struct packed {
        logic [15:0] opcode;
        logic [31:0] addr;
        logic [7:0] p1;
        logic [7:0] p0;
        logic [6:0] plen;
    } hvc_cmd_t;

    typedef struct packed {
        logic [7:0] ret;
        logic [7:0] code;
        logic [13:0] rsvd;
        logic evt;
        logic busy;
    } hvc_status_t;

    typedef enum logic [5:0] {
        S_IDLE = 6'b000001,
        S_RDA = 6'b000010,
        S_RDD = 6'b000100,
        S_WRA = 6'b001000,
        S_WRD = 6'b010000,
        S_WAKE = 6'b100000
    } hvc_state_t;

endpackage

/* File: rtl/hvc_byte_mem.sv */
/*
 * Single-port memory with registered read data, used both as the
 * command data buffer and as the byte-addressed target memory.
 * Assumes one access per clock; read data follows one edge later.
 */
module hvc_byte_mem import hvc_pkg::*; #(
    parameter int AW = 6,
    parameter int DW = 8
) (
    // Clock
    input wire logic clk,
    // Access port
    input wire logic we,
    input wire logic [AW-1:0] addr,
    input wire logic [DW-1:0] wdata,
    output logic [DW-1:0] rdata_q
);
    logic [DW-1:0] mem [2**AW];

    // No reset: contents are data, not control
    always_ff @(posedge clk) begin
        if (we) begin
            mem[addr] <= wdata;
        end
        rdata_q <= mem[addr];
    end
endmodule // hvc_byte_mem

/* File: rtl/hvc_cmd_handler.sv */
/*
 * Vendor command handler: command registers over APB, a byte engine for
 * memory reads and writes, power mode, radio activity pin and tx power.
 * Assumes radio and link status inputs synchronous to pclk.
 */
// Chosen here: the placing of the registers and register access over APB.
// Function
// - Test end stops the transmitter test and returns a 16-bit packet count.
// - Test end is refused while advertising, scanning or a connection runs.
// - Count is returned for counting and modulated test modes only.
// - Every command ends with a completion event carrying a status byte.
// - Addressed read takes address and length, returns bytes from consecutive addresses.
// - Read longer than 64 bytes returns invalid parameter, no data.
// - Continued read starts just after the last byte previously read.
// - Addressed write stores payload at address, count from length, at most 64.
// - Continued write starts just after the last byte previously written.
// - Power mode command enters active, processor sleep, sleep or deep sleep.
// - Active request while already active leaves the power state alone.
// - Event precedes a sleep entry; follows reaching active on wake (here set on the same edge as power_mode).
// - Activity pin is asserted while the radio transmits or receives.
// - Enable byte: 0 off, 1 low active, 2 high active, others reserved.
// - Second byte picks the activity pin index from zero upward.
// - Tx power level steps 0 to 17; codes from 0x12 reserved.
// - Level change during radio activity waits until the activity ends.
// - Tx power answer returns the maximum step, lowered by supply condition.
module hvc_cmd_handler import hvc_pkg::*; #(
    parameter int NGPIO = 8,
    parameter int MEM_AW = 8
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Radio and link status
    input wire logic radio_busy,
    input wire logic link_activity,
    input wire logic [7:0] test_mode,
    input wire logic [15:0] test_pkt_count,
    input wire logic [4:0] supply_max_step,
    input wire logic wake_done,
    // Control outputs
    output logic tx_test_stop,
    output logic sleep_req,
    output logic wake_req,
    output logic [1:0] power_mode,
    output logic [4:0] tx_level,
    output logic [NGPIO-1:0] act_gpio_o,
    output logic [NGPIO-1:0] act_gpio_oe_n
);
    function automatic logic reg_hit(input logic [11:0] a, input logic [11:0] off);
        reg_hit = (a[11:2] == off[11:2]);
    endfunction

    hvc_state_t st_q;
    hvc_state_t d_next;
    hvc_cmd_t cmd_q;
    hvc_status_t stat;
    logic evt_q, pend_q, act_en_q, act_pol_q, busy;
    logic [7:0] code_q, ret_q, act_sel_q, d_status, d_ret, buf_rdata, mem_rdata;
    logic [15:0] count_q;
    logic [4:0] pend_lvl_q, txp_max;
    logic [1:0] sleep_pend_q;
    logic [6:0] cnt_q, d_len;
    logic [5:0] idx_q, buf_addr;
    logic [31:0] cur_q, rd_next_q, wr_next_q, d_start, prdata_d;
    logic apb_access, apb_done, apb_wr, win_hit, mapped, go, ok, last_byte, sleep_go;
    logic buf_we, mem_we;
    logic [7:0] buf_wdata;

    // APB decode
    assign busy = (st_q != S_IDLE);
    assign apb_access = psel & penable;
    assign apb_done = apb_access & pready;
    assign apb_wr = apb_done & pwrite;
    assign win_hit = (paddr[11:8] == OFF_DATA[11:8]);
    assign mapped = win_hit | reg_hit(paddr, OFF_OPCODE) | reg_hit(paddr, OFF_ADDR)
        | reg_hit(paddr, OFF_PARAM) | reg_hit(paddr, OFF_PLEN) | reg_hit(paddr, OFF_GO)
        | reg_hit(paddr, OFF_STATUS) | reg_hit(paddr, OFF_RESULT) | reg_hit(paddr, OFF_STATE);
    assign go = apb_wr & reg_hit(paddr, OFF_GO) & ~busy;
    assign stat = '{ret: ret_q, code: code_q, rsvd: '0, evt: evt_q, busy: busy};

    assign txp_max = (supply_max_step < TXP_LAST[4:0]) ? supply_max_step : TXP_LAST[4:0];

    always_comb begin
        d_status = ST_SUCCESS;
        d_next = S_IDLE;
        d_len = 7'h00;
        d_start = cmd_q.addr;
        d_ret = 8'h00;
        case (cmd_q.opcode)
            OP_TX_TEST_END: begin
                if (link_activity) begin
                    d_status = ST_DISALLOWED;
                end
            end
            OP_ADDR_READ, OP_CONT_READ: begin
                d_start = (cmd_q.opcode == OP_ADDR_READ) ? cmd_q.addr : rd_next_q;
                d_len = cmd_q.p0[6:0];
                if (cmd_q.p0 > MAX_XFER) begin
                    d_status = ST_INVALID_PARAM;
                end else if (cmd_q.p0 != 8'h00) begin
                    d_next = S_RDA;
                end
            end
            OP_ADDR_WRITE, OP_CONT_WRITE: begin
                d_start = (cmd_q.opcode == OP_ADDR_WRITE) ? cmd_q.addr : wr_next_q;
                d_len = cmd_q.plen;
                if ({1'b0, cmd_q.plen} > MAX_XFER) begin
                    d_status = ST_INVALID_PARAM;
                end else if (cmd_q.plen != 7'h00) begin
                    d_next = S_WRA;
                end
            end
            OP_POWER_MODE: begin
                if (cmd_q.p0 > PM_LAST) begin
                    d_status = ST_INVALID_PARAM;
                end else if (cmd_q.p0 == PM_ACTIVE && power_mode != RST_PMODE) begin
                    d_next = S_WAKE;
                end
            end
            OP_RADIO_ACT: begin
                if (cmd_q.p0 > ACT_HIGH || cmd_q.p1 >= 8'(NGPIO)) begin
                    d_status = ST_INVALID_PARAM;
                end
            end
            OP_TX_POWER: begin
                d_ret = {3'h0, txp_max};
                if (cmd_q.p0 > TXP_LAST) begin
                    d_status = ST_INVALID_PARAM;
                end
            end
            default: d_status = ST_UNKNOWN_CMD;
        endcase
    end

    assign ok = (d_status == ST_SUCCESS);
    assign last_byte = (cnt_q == 7'h01);
    assign sleep_go = go & ok & (cmd_q.opcode == OP_POWER_MODE) & (cmd_q.p0 != PM_ACTIVE);

    // Buffer and target ports: engine owns the buffer while busy
    assign buf_addr = busy ? idx_q : paddr[7:2];
    assign buf_we = busy ? st_q == S_RDD : apb_wr & win_hit;
    assign buf_wdata = busy ? mem_rdata : pwdata[7:0];
    assign mem_we = (st_q == S_WRD);

    hvc_byte_mem #(.AW(6), .DW(8)) u_buf (
        .clk(pclk),
        .we(buf_we),
        .addr(buf_addr),
        .wdata(buf_wdata),
        .rdata_q(buf_rdata)
    );

    hvc_byte_mem #(.AW(MEM_AW), .DW(8)) u_mem (
        .clk(pclk),
        .we(mem_we),
        .addr(cur_q[MEM_AW-1:0]),
        .wdata(buf_rdata),
        .rdata_q(mem_rdata)
    );

    always_comb begin
        prdata_d = 32'h0000_0000;
        if (win_hit) prdata_d = {24'h000000, buf_rdata};
        if (reg_hit(paddr, OFF_OPCODE)) prdata_d = {16'h0000, cmd_q.opcode};
        if (reg_hit(paddr, OFF_ADDR)) prdata_d = cmd_q.addr;
        if (reg_hit(paddr, OFF_PARAM)) prdata_d = {16'h0000, cmd_q.p1, cmd_q.p0};
        if (reg_hit(paddr, OFF_PLEN)) prdata_d = {25'h0000000, cmd_q.plen};
        if (reg_hit(paddr, OFF_STATUS)) prdata_d = stat;
        if (reg_hit(paddr, OFF_RESULT)) prdata_d = {16'h0000, count_q};
        if (reg_hit(paddr, OFF_STATE)) prdata_d = {act_sel_q, 8'h00, pend_lvl_q, pend_q,
            power_mode, act_en_q, act_pol_q, 1'b0, tx_level};
    end

    // One wait state so buffer read data is ready in time
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= apb_access & ~pready;
            pslverr <= apb_access & ~pready & (~mapped | (pwrite & busy & (win_hit
                | reg_hit(paddr, OFF_GO))));
            prdata <= prdata_d;
        end
    end

    // Command registers frozen while the engine runs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmd_q <= '0;
        end else if (apb_wr & ~busy) begin
            if (reg_hit(paddr, OFF_OPCODE)) cmd_q.opcode <= pwdata[15:0];
            if (reg_hit(paddr, OFF_ADDR)) cmd_q.addr <= pwdata;
            if (reg_hit(paddr, OFF_PARAM)) {cmd_q.p1, cmd_q.p0} <= pwdata[15:0];
            if (reg_hit(paddr, OFF_PLEN)) cmd_q.plen <= pwdata[6:0];
        end
    end

    // Byte engine
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= S_IDLE;
            cnt_q <= 7'h00;
            idx_q <= 6'h00;
            cur_q <= 32'h0000_0000;
            rd_next_q <= 32'h0000_0000;
            wr_next_q <= 32'h0000_0000;
        end else begin
            case (st_q)
                S_IDLE: begin
                    if (go & ok) begin
                        st_q <= d_next;
                        cnt_q <= d_len;
                        idx_q <= 6'h00;
                        cur_q <= d_start;
                        if (cmd_q.opcode == OP_ADDR_READ || cmd_q.opcode == OP_CONT_READ)
                            rd_next_q <= d_start + {25'h0000000, d_len};
                        if (cmd_q.opcode == OP_ADDR_WRITE || cmd_q.opcode == OP_CONT_WRITE)
                            wr_next_q <= d_start + {25'h0000000, d_len};
                    end
                end
                S_RDA: st_q <= S_RDD;
                S_WRA: st_q <= S_WRD;
                S_RDD, S_WRD: begin
                    idx_q <= idx_q + 6'h01;
                    cur_q <= cur_q + 32'h0000_0001;
                    cnt_q <= cnt_q - 7'h01;
                    st_q <= last_byte ? S_IDLE : ((st_q == S_RDD) ? S_RDA : S_WRA);
                end
                S_WAKE: if (wake_done) st_q <= S_IDLE;
                default: st_q <= S_IDLE;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            evt_q <= 1'b0;
            code_q <= ST_SUCCESS;
            ret_q <= 8'h00;
        end else begin
            if (go) begin
                evt_q <= 1'b0;
                code_q <= d_status;
                ret_q <= d_ret;
            end
            // Completion sets after the clear so a set is never lost
            if ((go & (~ok | d_next == S_IDLE)) | ((st_q == S_RDD || st_q == S_WRD)
                & last_byte) | (st_q == S_WAKE & wake_done))
                evt_q <= 1'b1;
        end
    end

    // Test end, power mode and tx power
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_test_stop <= 1'b0;
            count_q <= 16'h0000;
            sleep_req <= 1'b0;
            wake_req <= 1'b0;
            sleep_pend_q <= RST_PMODE;
            power_mode <= RST_PMODE;
            tx_level <= RST_TX_LEVEL;
            pend_q <= 1'b0;
            pend_lvl_q <= RST_TX_LEVEL;
        end else begin
            tx_test_stop <= go & ok & (cmd_q.opcode == OP_TX_TEST_END);
            if (go & ok & (cmd_q.opcode == OP_TX_TEST_END))
                count_q <= (test_mode == TEST_MODE_COUNT || test_mode == TEST_MODE_CM)
                    ? test_pkt_count : 16'h0000;
            // Sleep applied one edge after the event
            sleep_req <= sleep_go;
            if (sleep_go) sleep_pend_q <= cmd_q.p0[1:0];
            if (sleep_req) power_mode <= sleep_pend_q;
            // Wake only when not already active
            wake_req <= go & ok & (d_next == S_WAKE);
            if (st_q == S_WAKE & wake_done) power_mode <= RST_PMODE;
            if (go & ok & (cmd_q.opcode == OP_TX_POWER)) begin
                pend_q <= radio_busy;
                pend_lvl_q <= cmd_q.p0[4:0];
                if (!radio_busy) tx_level <= cmd_q.p0[4:0];
            end else if (pend_q & ~radio_busy) begin
                pend_q <= 1'b0;
                tx_level <= pend_lvl_q;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            act_en_q <= 1'b0;
            act_pol_q <= 1'b0;
            act_sel_q <= 8'h00;
        end else if (go & ok & (cmd_q.opcode == OP_RADIO_ACT)) begin
            act_en_q <= (cmd_q.p0 != ACT_OFF);
            act_pol_q <= (cmd_q.p0 == ACT_HIGH);
            act_sel_q <= cmd_q.p1;
        end
    end

    for (genvar i = 0; i < NGPIO; i++) begin : g_act
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                act_gpio_o[i] <= 1'b0;
                act_gpio_oe_n[i] <= 1'b1;
            end else begin
                act_gpio_o[i] <= act_en_q & (act_sel_q == 8'(i)) & (radio_busy ~^ act_pol_q);
                act_gpio_oe_n[i] <= ~(act_en_q & (act_sel_q == 8'(i)));
            end
        end
    end

    sequence s_one_read;
        st_q == S_RDA ##1 st_q == S_RDD ##1 st_q == S_IDLE && evt_q;
    endsequence

    sequence s_sleep_entry(logic [1:0] m);
        evt_q && sleep_req ##1 power_mode == m;
    endsequence

    a_test_end_done: assert property (@(posedge pclk) disable iff (!presetn)
        go && cmd_q.opcode == OP_TX_TEST_END && !link_activity |=> tx_test_stop && evt_q)
        else $error("test end not completed");
    a_test_end_refuse: assert property (@(posedge pclk) disable iff (!presetn)
        go && cmd_q.opcode == OP_TX_TEST_END && link_activity
        |=> !tx_test_stop && code_q == ST_DISALLOWED)
        else $error("test end accepted during link activity");
    a_read_walk: assert property (@(posedge pclk) disable iff (!presetn)
        go && (cmd_q.opcode == OP_ADDR_READ || cmd_q.opcode == OP_CONT_READ)
        && cmd_q.p0 == 8'h01 |=> s_one_read)
        else $error("single byte read sequence wrong");
    a_read_too_long: assert property (@(posedge pclk) disable iff (!presetn)
        go && cmd_q.opcode == OP_ADDR_READ && cmd_q.p0 > MAX_XFER
        |=> st_q == S_IDLE && code_q == ST_INVALID_PARAM && evt_q)
        else $error("oversize read not refused");
    a_cont_read_addr: assert property (@(posedge pclk) disable iff (!presetn)
        go && ok && cmd_q.opcode == OP_CONT_READ |=> cur_q == $past(rd_next_q))
        else $error("continued read start wrong");
    a_active_noop: assert property (@(posedge pclk) disable iff (!presetn)
        go && cmd_q.opcode == OP_POWER_MODE && cmd_q.p0 == PM_ACTIVE && power_mode == 2'h0
        |=> !wake_req && evt_q && power_mode == 2'h0)
        else $error("active request disturbed power state");
    a_sleep_order: assert property (@(posedge pclk) disable iff (!presetn)
        sleep_go |=> s_sleep_entry($past(cmd_q.p0[1:0])))
        else $error("sleep entered before event");
    a_txp_defer: assert property (@(posedge pclk) disable iff (!presetn)
        pend_q && radio_busy && !go |=> $stable(tx_level))
        else $error("tx level changed during radio activity");
    a_act_reserved: assert property (@(posedge pclk) disable iff (!presetn)
        go && cmd_q.opcode == OP_RADIO_ACT && cmd_q.p0 > ACT_HIGH
        |=> $stable(act_en_q) && code_q == ST_INVALID_PARAM)
        else $error("reserved activity code accepted");
endmodule // hvc_cmd_handler

/* File: tb/hvc_radio_model.sv */
/* Radio and power partner: echoes bench traffic as radio_busy, answers wake.
   Assumes the handler's pclk and presetn. */
module hvc_radio_model (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Bench stimulus and handshake
    input wire logic traffic,
    input wire logic wake_req,
    output logic radio_busy,
    output logic wake_done
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [2:0] wait_q;
    // Slow wake, so an early event would show
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wait_q <= 3'h0;
            radio_busy <= 1'b0;
            wake_done <= 1'b0;
        end else begin
            radio_busy <= traffic;
            wake_done <= (wait_q == 3'h1);
            if (wake_req)
                wait_q <= 3'h5;
            else if (wait_q != 3'h0)
                wait_q <= wait_q - 3'h1;
        end
    end
endmodule // hvc_radio_model

/* File: tb/hvc_cmd_handler_tb.sv */
/* Self-checking bench of the command handler over APB.
   Assumes the radio partner model and default parameters. */
module hvc_cmd_handler_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import hvc_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata;
    logic pready, pslverr, radio_busy, wake_done, traffic = 0, link_activity = 0;
    logic [7:0] test_mode = 0;
    logic [15:0] test_pkt_count = 0;
    logic [4:0] supply_max_step = 5'h14, tx_level;
    logic tx_test_stop, sleep_req, wake_req;
    logic [1:0] power_mode;
    logic [7:0] act_gpio_o, act_gpio_oe_n;
    int errors = 0, compares = 0;
    int stops = 0, sleeps = 0, wakes = 0;
    // Pulses counted at rising edges, so each one-cycle pulse counts once
    always @(posedge pclk) begin
        if (presetn) begin
            stops <= stops + 32'(tx_test_stop);
            sleeps <= sleeps + 32'(sleep_req);
            wakes <= wakes + 32'(wake_req);
        end
    end
    hvc_cmd_handler dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .radio_busy(radio_busy), .link_activity(link_activity),
        .test_mode(test_mode), .test_pkt_count(test_pkt_count),
        .supply_max_step(supply_max_step), .wake_done(wake_done),
        .tx_test_stop(tx_test_stop), .sleep_req(sleep_req), .wake_req(wake_req),
        .power_mode(power_mode), .tx_level(tx_level), .act_gpio_o(act_gpio_o),
        .act_gpio_oe_n(act_gpio_oe_n));
    hvc_radio_model radio (.pclk(pclk), .presetn(presetn), .traffic(traffic),
        .wake_req(wake_req), .radio_busy(radio_busy), .wake_done(wake_done));
    initial begin
        forever #50 pclk = ~pclk;
    end
    task automatic complete_run;
        if (errors == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
        compares++;
        if (g !== x) begin
            errors++;
            $display("wrong value %s expected %h seen %h", nm, x, g);
        end
    endtask
    // Request held until pready is seen at a rising edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
        output logic [31:0] r, output logic e);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) begin
            errors++;
            complete_run();
        end
    endtask
    task automatic cmd(input logic [15:0] op, input logic [31:0] a, input logic [7:0] p1,
        input logic [7:0] p0, input logic [6:0] pl, output logic [31:0] st);
        logic [31:0] r;
        logic e;
        int n;
        apb(1'b1, OFF_OPCODE, {16'h0, op}, r, e);
        apb(1'b1, OFF_ADDR, a, r, e);
        apb(1'b1, OFF_PARAM, {16'h0, p1, p0}, r, e);
        apb(1'b1, OFF_PLEN, {25'h0, pl}, r, e);
        apb(1'b1, OFF_GO, 32'h1, r, e);
        n = 0;
        // next command only after the event
        do begin
            apb(1'b0, OFF_STATUS, 32'h0, st, e);
            n++;
        end while (st[1] !== 1'b1 && n < 200);
        if (n >= 200) begin
            errors++;
            complete_run();
        end
    endtask
    task automatic buf_io(input logic w, input int i, input logic [7:0] v);
        logic [31:0] r;
        logic e;
        apb(w, OFF_DATA + 12'(4 * i), {24'h0, v}, r, e);
        if (!w)
            chk("buffer byte", {24'h0, v}, r);
    endtask
    task automatic t_test_end;
        logic [31:0] s, r;
        logic e;
        link_activity <= 1'b1;
        cmd(OP_TX_TEST_END, 0, 0, 0, 0, s);
        chk("busy link status", {24'h0, ST_DISALLOWED}, {24'h0, s[23:16]});
        link_activity <= 1'b0;
        test_mode <= TEST_MODE_CM;
        test_pkt_count <= 16'h1234;
        cmd(OP_TX_TEST_END, 0, 0, 0, 0, s);
        chk("test end status", {24'h0, ST_SUCCESS}, {24'h0, s[23:16]});
        apb(1'b0, OFF_RESULT, 0, r, e);
        chk("packet count", 32'h1234, {16'h0, r[15:0]});
        test_mode <= 8'h02;
        cmd(OP_TX_TEST_END, 0, 0, 0, 0, s);
        apb(1'b0, OFF_RESULT, 0, r, e);
        chk("count other mode", 32'h0, {16'h0, r[15:0]});
        apb(1'b0, 12'h020, 0, r, e);
        chk("unmapped error", 32'h1, {31'h0, e});
        chk("stop pulses", 32'h2, stops);
    endtask
    task automatic t_mem;
        logic [31:0] s;
        for (int i = 0; i < 3; i++)
            buf_io(1'b1, i, 8'ha1 + 8'(i));
        cmd(OP_ADDR_WRITE, 32'h10, 0, 0, 7'h03, s);
        buf_io(1'b1, 0, 8'hb1);
        buf_io(1'b1, 1, 8'hb2);
        cmd(OP_CONT_WRITE, 0, 0, 0, 7'h02, s);
        cmd(OP_ADDR_READ, 32'h10, 0, 8'h04, 0, s);
        for (int i = 0; i < 3; i++)
            buf_io(1'b0, i, 8'ha1 + 8'(i));
        buf_io(1'b0, 3, 8'hb1);
        cmd(OP_CONT_READ, 0, 0, 8'h01, 0, s);
        buf_io(1'b0, 0, 8'hb2);
        cmd(OP_ADDR_READ, 32'h10, 0, 8'h41, 0, s);
        chk("long read", {24'h0, ST_INVALID_PARAM}, {24'h0, s[23:16]});
        cmd(OP_ADDR_WRITE, 32'h10, 0, 0, 7'h41, s);
        chk("long write", {24'h0, ST_INVALID_PARAM}, {24'h0, s[23:16]});
    endtask
    task automatic t_power;
        logic [31:0] s;
        cmd(OP_POWER_MODE, 0, 0, 8'h04, 0, s);
        chk("bad mode", {24'h0, ST_INVALID_PARAM}, {24'h0, s[23:16]});
        for (int m = 1; m < 4; m++) begin
            cmd(OP_POWER_MODE, 0, 0, 8'(m), 0, s);
            chk("sleep mode", 32'(m), {30'h0, power_mode});
            cmd(OP_POWER_MODE, 0, 0, PM_ACTIVE, 0, s);
            chk("awake at event", 32'h0, {30'h0, power_mode});
        end
        cmd(OP_POWER_MODE, 0, 0, PM_ACTIVE, 0, s);
        chk("active again", {24'h0, ST_SUCCESS}, {22'h0, power_mode, s[23:16]});
        chk("sleep pulses", 32'h3, sleeps);
        chk("wake pulses", 32'h3, wakes);
    endtask
    task automatic t_act;
        logic [31:0] s;
        traffic <= 1'b1;
        cmd(OP_RADIO_ACT, 0, 8'h03, ACT_HIGH, 0, s);
        chk("pin enable", 32'hf7, {24'h0, act_gpio_oe_n});
        chk("high active", 32'h08, {24'h0, act_gpio_o});
        cmd(OP_RADIO_ACT, 0, 8'h03, ACT_LOW, 0, s);
        chk("low active", 32'h0, {24'h0, act_gpio_o});
        cmd(OP_RADIO_ACT, 0, 8'h08, ACT_HIGH, 0, s);
        chk("bad pin", {24'h0, ST_INVALID_PARAM}, {24'h0, s[23:16]});
        cmd(OP_RADIO_ACT, 0, 8'h01, 8'h03, 0, s);
        chk("reserved enable", 32'hf7, {24'h0, act_gpio_oe_n});
        cmd(OP_RADIO_ACT, 0, 8'h03, ACT_OFF, 0, s);
        chk("disabled", 32'hff, {24'h0, act_gpio_oe_n});
    endtask
    task automatic t_txp;
        logic [31:0] s;
        cmd(OP_TX_POWER, 0, 0, 8'h05, 0, s);
        chk("max step", 32'h11, {24'h0, s[31:24]});
        chk("held level", 32'h0, {27'h0, tx_level});
        traffic <= 1'b0;
        repeat (4) @(posedge pclk);
        @(negedge pclk);
        chk("applied level", 32'h5, {27'h0, tx_level});
        @(posedge pclk);
        supply_max_step <= 5'h09;
        cmd(OP_TX_POWER, 0, 0, TXP_LAST, 0, s);
        chk("top level", 32'h0911, {19'h0, s[28:24], 3'h0, tx_level});
        cmd(OP_TX_POWER, 0, 0, 8'h12, 0, s);
        chk("reserved level", 32'h1211, {16'h0, s[23:16], 3'h0, tx_level});
    endtask
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(negedge pclk);
        chk("reset outputs", 32'h7f80, {act_gpio_oe_n, power_mode, tx_level});
        @(posedge pclk);
        t_test_end();
        t_mem();
        t_power();
        t_act();
        t_txp();
        complete_run();
    end
endmodule // hvc_cmd_handler_tb
